// ===== logic/temp_alarm_pkg.sv
`default_nettype none
package temp_alarm_pkg;
  localparam int          TEMP_W         = 8;
  localparam logic [7:0]  HYST_RESET     = 8'h0A;  // ten degrees
  localparam logic [7:0]  LOW_LIM_RESET  = 8'h00;  // zero degrees
  localparam logic [7:0]  HIGH_LIM_RESET = 8'h55;
  localparam logic [7:0]  FS_LIM_RESET   = 8'h55;
  localparam logic [7:0]  UNDERRANGE     = 8'h80;  // -128
  localparam logic [7:0]  OFFSET_RESET   = 8'h00;
  localparam int          OPEN_BIT       = 2;
  localparam int          STATUS_W       = 8;

  // per channel limits; index 0 local, 1 remote
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] fs;
  } limits_s;

  // one finished conversion of both channels
  typedef struct packed {
    logic       valid;
    logic       start;
    logic [7:0] local_t;
    logic [7:0] remote_raw;
    logic       underrange;
  } conv_s;
endpackage
`default_nettype wire

// ===== logic/failsafe_chan.sv
`default_nettype none
module failsafe_chan
  import temp_alarm_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_update,
  input  wire logic [7:0] i_temp,
  input  wire logic [7:0] i_fs_lim,
  input  wire logic [7:0] i_hyst,
  output logic            o_active
);
  typedef struct packed {
    logic active;
  } fs_state_s;

  fs_state_s   st_ff;
  fs_state_s   nxt_st;
  logic signed [9:0] release_pt;

  // release point computed wide so a large hysteresis never wraps
  always_comb begin
    release_pt = 10'(signed'(i_fs_lim)) - 10'(signed'({1'b0, i_hyst}));
    nxt_st     = st_ff;
    if (i_update) begin
      if ($signed(i_temp) > $signed(i_fs_lim)) begin
        nxt_st.active = 1'b1;
      end else if (10'(signed'(i_temp)) < release_pt) begin
        nxt_st.active = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_active = st_ff.active;

  fs_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_ff.active && !i_update) |=> st_ff.active)
    else $error("fail-safe dropped without a new result");
endmodule
`default_nettype wire

// ===== logic/temp_limit_alarm.sv
`default_nettype none
module temp_limit_alarm
  import temp_alarm_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire conv_s        i_conv,
  input  wire logic         i_open_diode,
  input  wire logic         i_alert_mask,
  input  wire logic         i_ara_done,
  input  wire logic         i_lim_we,
  input  wire logic         i_lim_sel,
  input  wire limits_s      i_lim_wdata,
  input  wire logic         i_hyst_we,
  input  wire logic [7:0]   i_hyst_wdata,
  input  wire logic         i_offset_we,
  input  wire logic [7:0]   i_offset_wdata,
  input  wire logic         i_status_clr,
  output logic [7:0]        o_local_temp,
  output logic [7:0]        o_remote_temp,
  output logic [STATUS_W-1:0] o_status,
  output logic [7:0]        o_hyst,
  output logic              o_alert_n,
  output logic              o_alert_oe,
  output logic              o_overtemp_failsafe_n,
  output logic              o_overtemp_failsafe_oe
);
  typedef struct packed {
    logic [1:0]         open_sync;
    limits_s            lim_loc;
    limits_s            lim_rem;
    logic [7:0]         hyst;
    logic [7:0]         offset;
    logic [7:0]         local_t;
    logic [7:0]         remote_t;
    logic               open_flag;
    logic               alert_latch;
    logic [STATUS_W-1:0] status;
    logic               upd;
  } state_s;

  state_s      st_ff;
  state_s      nxt_st;
  logic        fs_loc;
  logic        fs_rem;
  logic        viol_loc;
  logic        viol_rem;
  logic        cause;
  logic [8:0]  sum_w;
  logic [7:0]  rem_corr;

  // remote correction with saturation so an offset cannot wrap the sign
  always_comb begin
    sum_w = {i_conv.remote_raw[7], i_conv.remote_raw}
          + {st_ff.offset[7], st_ff.offset};
    if (sum_w[8] != sum_w[7]) begin
      rem_corr = sum_w[8] ? 8'h80 : 8'h7F;
    end else begin
      rem_corr = sum_w[7:0];
    end
    if (i_conv.underrange) begin
      rem_corr = UNDERRANGE;
    end
  end

  // violations on stored results; in-band gives nothing
  always_comb begin
    viol_loc = ($signed(st_ff.local_t) <= $signed(st_ff.lim_loc.low))
            || ($signed(st_ff.local_t) > $signed(st_ff.lim_loc.high));
    viol_rem = ($signed(st_ff.remote_t) <= $signed(st_ff.lim_rem.low))
            || ($signed(st_ff.remote_t) > $signed(st_ff.lim_rem.high));
    cause    = viol_loc || viol_rem || st_ff.open_flag;
  end

  // next state
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.open_sync = {st_ff.open_sync[0], i_open_diode};
    nxt_st.upd       = 1'b0;
    if (i_lim_we) begin
      if (i_lim_sel) begin
        nxt_st.lim_rem = i_lim_wdata;
      end else begin
        nxt_st.lim_loc = i_lim_wdata;
      end
    end
    if (i_hyst_we) begin
      nxt_st.hyst = i_hyst_wdata;
    end
    if (i_offset_we) begin
      nxt_st.offset = i_offset_wdata;
    end
    // comparator only looked at when a conversion starts
    if (i_conv.start) begin
      nxt_st.open_flag = st_ff.open_sync[1];
    end
    if (i_conv.valid) begin
      nxt_st.local_t  = i_conv.local_t;
      nxt_st.remote_t = rem_corr;
      nxt_st.upd      = 1'b1;
    end
    // sticky status: a set in the clear cycle wins
    if (i_status_clr) begin
      nxt_st.status = '0;
    end
    if (i_conv.start && st_ff.open_sync[1]) begin
      nxt_st.status[OPEN_BIT] = 1'b1;
    end
    // alert latches; released only via alert response with cause gone
    if (cause) begin
      nxt_st.alert_latch = 1'b1;
    end else if (i_ara_done) begin
      nxt_st.alert_latch = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_ff             <= '0;
      st_ff.lim_loc     <= '{low: LOW_LIM_RESET, high: HIGH_LIM_RESET, fs: FS_LIM_RESET};
      st_ff.lim_rem     <= '{low: LOW_LIM_RESET, high: HIGH_LIM_RESET, fs: FS_LIM_RESET};
      st_ff.hyst        <= HYST_RESET;
      st_ff.offset      <= OFFSET_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  failsafe_chan u_fs_loc (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_update (st_ff.upd),
    .i_temp   (st_ff.local_t),
    .i_fs_lim (st_ff.lim_loc.fs),
    .i_hyst   (st_ff.hyst),
    .o_active (fs_loc)
  );

  failsafe_chan u_fs_rem (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_update (st_ff.upd),
    .i_temp   (st_ff.remote_t),
    .i_fs_lim (st_ff.lim_rem.fs),
    .i_hyst   (st_ff.hyst),
    .o_active (fs_rem)
  );

  // open-drain pins: enable high means pulling low
  assign o_alert_n              = !(st_ff.alert_latch && !i_alert_mask);
  assign o_alert_oe             = !o_alert_n;
  assign o_overtemp_failsafe_n  = !(fs_loc || fs_rem);
  assign o_overtemp_failsafe_oe = !o_overtemp_failsafe_n;
  assign o_local_temp           = st_ff.local_t;
  assign o_remote_temp          = st_ff.remote_t;
  assign o_status               = st_ff.status;
  assign o_hyst                 = st_ff.hyst;

  low_alarm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ($signed(st_ff.local_t) <= $signed(st_ff.lim_loc.low)) |=> st_ff.alert_latch)
    else $error("low violation did not latch alert");
  high_alarm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ($signed(st_ff.remote_t) > $signed(st_ff.lim_rem.high)) |=> st_ff.alert_latch)
    else $error("high violation did not latch alert");
  mask_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_alert_mask |-> o_alert_n)
    else $error("masked alert still driven");
  fs_nomask_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_ff.upd && (($signed(st_ff.local_t) > $signed(st_ff.lim_loc.fs))
                || ($signed(st_ff.remote_t) > $signed(st_ff.lim_rem.fs))))
    |=> !o_overtemp_failsafe_n && o_overtemp_failsafe_oe)
    else $error("fail-safe not driven");
  short_code_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_conv.valid && i_conv.underrange) |=> st_ff.remote_t == UNDERRANGE)
    else $error("under-range not reported as -128");
  short_alarm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_ff.remote_t == UNDERRANGE) |=> st_ff.alert_latch)
    else $error("-128 did not raise alert");
  open_status_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_conv.start && st_ff.open_sync[1]) |=> st_ff.status[OPEN_BIT])
    else $error("open diode not flagged");
  open_alarm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st_ff.open_flag |=> st_ff.alert_latch)
    else $error("open diode did not raise alert");
  ara_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_ff.alert_latch && cause) |=> st_ff.alert_latch)
    else $error("alert released while cause present");
  offset_add_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_conv.valid && !i_conv.underrange && !i_offset_we && sum_w[8] == sum_w[7])
    |=> st_ff.remote_t == 8'($past(i_conv.remote_raw) + $past(st_ff.offset)))
    else $error("offset not applied");
  hyst_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_hyst_we |=> o_hyst == $past(i_hyst_wdata))
    else $error("hysteresis write lost");

  alarm_seen_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) !o_alert_n);
  fs_seen_c:    cover property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_overtemp_failsafe_n ##[1:50] o_overtemp_failsafe_n);
  ara_clr_c:    cover property (@(posedge i_clk) disable iff (!i_rst_n)
    st_ff.alert_latch ##1 !st_ff.alert_latch);
endmodule
`default_nettype wire

// ===== verification/alert_host_model.sv
`default_nettype none
// host side: services a low alert line after a service delay
module alert_host_model #(
  parameter int DLY = 20
) (
  input  wire logic i_clk,
  input  wire logic i_alert_pin,
  output logic      o_ara_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt = 0;
  initial o_ara_done = 1'b0;
  // one alert response per service interval while the line stays low
  always @(posedge i_clk) begin
    o_ara_done <= 1'b0;
    wait_cnt   <= (i_alert_pin === 1'b0) ? wait_cnt + 1 : 0;
    if (wait_cnt == DLY) begin
      o_ara_done <= 1'b1;
      wait_cnt   <= 0;
    end
  end
endmodule
`default_nettype wire

// ===== verification/test_temp_limit_alarm.sv
`default_nettype none
module test_temp_limit_alarm
  import temp_alarm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_clk = 0, i_rst_n = 0, open_d = 0, mask = 0, ara, alert_pin;
  logic       lim_we, lim_sel, hyst_we, off_we, st_clr;
  logic [7:0] hyst_wd, off_wd, loc_t, rem_t, status, hyst;
  logic       alert_n, alert_oe, fs_n, fs_oe;
  conv_s      conv;
  limits_s    lim_wd;
  int         fails = 0, checked = 0, cycles = 0;

  // open drain alert line with pull-up
  assign alert_pin = alert_oe ? 1'b0 : 1'b1;

  initial forever #2.5 i_clk = ~i_clk;

  temp_limit_alarm u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_conv(conv),
    .i_open_diode(open_d), .i_alert_mask(mask), .i_ara_done(ara), .i_lim_we(lim_we),
    .i_lim_sel(lim_sel), .i_lim_wdata(lim_wd), .i_hyst_we(hyst_we), .i_hyst_wdata(hyst_wd),
    .i_offset_we(off_we), .i_offset_wdata(off_wd), .i_status_clr(st_clr),
    .o_local_temp(loc_t), .o_remote_temp(rem_t), .o_status(status), .o_hyst(hyst),
    .o_alert_n(alert_n), .o_alert_oe(alert_oe), .o_overtemp_failsafe_n(fs_n),
    .o_overtemp_failsafe_oe(fs_oe));

  alert_host_model #(.DLY(20)) u_host (.i_clk(i_clk), .i_alert_pin(alert_pin),
    .o_ara_done(ara));

  task automatic close_out();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // settle past the edge so design updates have landed
  task automatic nap(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic run_conv(input logic [7:0] lt, input logic [7:0] rt, input logic ur);
    @(posedge i_clk);
    conv <= '{1'b1, 1'b1, lt, rt, ur};
    @(posedge i_clk);
    conv <= '0;
    nap(4);
  endtask

  task automatic set_lim(input logic sel, input logic [7:0] lo, input logic [7:0] hi,
                         input logic [7:0] fs);
    @(posedge i_clk);
    {lim_we, lim_sel, lim_wd} <= {1'b1, sel, lo, hi, fs};
    @(posedge i_clk);
    lim_we <= 1'b0;
  endtask

  // which 0 writes hysteresis, 1 writes offset
  task automatic wr(input bit which, input logic [7:0] d);
    @(posedge i_clk);
    {hyst_we, off_we, hyst_wd, off_wd} <= {!which, which, d, d};
    @(posedge i_clk);
    {hyst_we, off_we} <= 2'b00;
    nap(1);
  endtask

  // hang guard, well above the expected run length
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  initial begin
    conv = '0;
    lim_wd = '0;
    {lim_we, lim_sel, hyst_we, off_we, st_clr, hyst_wd, off_wd} = '0;
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    nap(3);
    chk("hyst reset", hyst, HYST_RESET);
    chk("status reset", status, 8'h00);
    chk("alert reset", 8'(alert_n), 8'h00);
    $display("test reset done");
    set_lim(1'b0, 8'h0A, 8'h50, 8'h60);
    set_lim(1'b1, 8'h0A, 8'h50, 8'h60);
    run_conv(8'h20, 8'h20, 1'b0);
    nap(30);
    chk("alert band", 8'(alert_n), 8'h01);
    run_conv(8'h20, 8'h51, 1'b0);
    chk("alert high", 8'(alert_n), 8'h00);
    chk("fs below", 8'(fs_n), 8'h01);
    run_conv(8'h20, 8'h50, 1'b0);
    chk("alert latched", 8'(alert_n), 8'h00);
    nap(30);
    chk("alert released", 8'(alert_n), 8'h01);
    $display("test limits done");
    // fail-safe: assert, hold inside hysteresis, release below limit minus hysteresis
    run_conv(8'h20, 8'h61, 1'b0);
    chk("fs remote", 8'(fs_n), 8'h00);
    chk("fs oe", 8'(fs_oe), 8'h01);
    run_conv(8'h20, 8'h56, 1'b0);
    chk("fs hold", 8'(fs_n), 8'h00);
    run_conv(8'h20, 8'h55, 1'b0);
    chk("fs release", 8'(fs_n), 8'h01);
    run_conv(8'h61, 8'h20, 1'b0);
    chk("fs local", 8'(fs_n), 8'h00);
    @(posedge i_clk);
    mask <= 1'b1;
    nap(2);
    chk("alert masked", 8'(alert_n), 8'h01);
    chk("fs unmasked", 8'(fs_n), 8'h00);
    @(posedge i_clk);
    mask <= 1'b0;
    run_conv(8'h20, 8'h20, 1'b0);
    nap(30);
    $display("test failsafe done");
    wr(1'b0, 8'h01);
    chk("hyst write", hyst, 8'h01);
    run_conv(8'h20, 8'h61, 1'b0);
    run_conv(8'h20, 8'h5F, 1'b0);
    chk("fs hyst hold", 8'(fs_n), 8'h00);
    run_conv(8'h20, 8'h5E, 1'b0);
    chk("fs hyst release", 8'(fs_n), 8'h01);
    nap(30);
    $display("test hysteresis done");
    wr(1'b1, 8'h03 + 8'h02);
    run_conv(8'h20, 8'h20, 1'b0);
    chk("offset plus", rem_t, 8'h25);
    chk("offset local", loc_t, 8'h20);
    wr(1'b1, 8'hFB);
    run_conv(8'h20, 8'h20, 1'b0);
    chk("offset minus", rem_t, 8'h1B);
    wr(1'b1, 8'h00);
    $display("test offset done");
    set_lim(1'b1, 8'h80, 8'h50, 8'h60);
    run_conv(8'h20, 8'h20, 1'b1);
    chk("underrange", rem_t, UNDERRANGE);
    chk("alert min low", 8'(alert_n), 8'h00);
    run_conv(8'h20, 8'h20, 1'b0);
    nap(30);
    $display("test underrange done");
    // comparator level goes through a two-flop sync before the conversion start
    @(posedge i_clk);
    open_d <= 1'b1;
    nap(4);
    run_conv(8'h20, 8'h20, 1'b0);
    chk("status open", status, 8'h04);
    chk("alert open", 8'(alert_n), 8'h00);
    @(posedge i_clk);
    open_d <= 1'b0;
    nap(4);
    run_conv(8'h20, 8'h20, 1'b0);
    @(posedge i_clk);
    st_clr <= 1'b1;
    @(posedge i_clk);
    st_clr <= 1'b0;
    nap(30);
    chk("status clear", status, 8'h00);
    chk("alert open gone", 8'(alert_n), 8'h01);
    $display("test open diode done");
    close_out();
  end
endmodule
`default_nettype wire
